/* spi_control_config_bank.sv */
// SPI control and configuration bank with APB slave and frame address check
// Function
// - Byte, halfword and word accesses all accepted
// - Protected registers write only while disabled
// - Control A resets zero, protected, synchronized
// - Bit 30 selects MSB or LSB first
// - Bit 29 sets clock idle level
// - Bit 28 sets sample and change edges
// - Mode number is polarity then phase
// - Frame format field selects plain or addressed
// - Addressed frame compares first byte to match
// - Pad field routes one of four inputs
// - Routed input is MISO master, MOSI slave
// - Shape settings apply without synchronization busy
// - Synchronized registers cross before access completes
// - Mode field 2 slave, 3 master
// - Enable reads back, busy until done
// - Soft reset clears all but debug
// - Enable set and clear registers per bit
`timescale 1ns/10ps
`include "spi_cfg_params.svh"
module spi_control_config_bank (
   // Clock and reset
   input  wire logic               i_mclk,
   input  wire logic               i_rst,
   // APB slave
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [7:0]         i_paddr,
   input  wire logic [3:0]         i_pstrb,
   input  wire spi_cfg_pkg::word_t i_pwdata,
   output spi_cfg_pkg::word_t      o_prdata,
   output logic                    o_pready,
   output logic                    o_pslverr,
   // Write protection and link pins
   input  wire logic               i_write_protect,
   input  wire logic [3:0]         i_pad,
   input  wire logic               i_sck,
   input  wire logic               i_ss_n,
   // Status towards the data path and system
   output logic                    o_serial_data_input,
   output logic                    o_enabled,
   output logic                    o_bit_order_select,
   output logic                    o_addr_hit,
   output logic                    o_irq
);
   import spi_cfg_pkg::*;

   word_t       control_a_ff;
   word_t       control_b_ff;
   logic [7:0]  baud_ff;
   logic [7:0]  irq_en_ff;
   logic [7:0]  irq_flags_ff;
   word_t       addr_match_ff;
   logic [8:0]  data_ff;
   logic [7:0]  dbg_ff;
   logic        en_active_ff;
   logic        pend_en_ff;
   logic        pend_rst_ff;
   logic [2:0]  ss_sync_ff;
   logic [2:0]  sck_sync_ff;
   logic [3:0]  pad_s1_ff;
   logic [3:0]  pad_s2_ff;
   logic [2:0]  bit_cnt_ff;
   logic [7:0]  shift_ff;
   logic        first_ff;
   logic        access;
   logic        wr;
   logic        sync_busy;
   logic        sync_done;
   logic        sync_start;
   logic        reg_ok;
   logic        lead_edge;
   logic        trail_edge;
   logic        sample_edge;
   logic        ss_fall;
   logic        rx_bit;
   logic [7:0]  rx_byte;
   logic [7:0]  ev;
   logic        sync_held_ff;
   word_t       wmask;
   word_t       rdata;
   xfer_mode_t  xmode;

   // Byte lanes come from the strobes alone; the address low bits are not used
   assign access = i_psel && i_penable;
   assign wr     = access && i_pwrite && reg_ok;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{i_pstrb[b]}};
      end
   end

   // Writes that set soft reset or change enable hold the bus until the crossing finishes
   assign sync_start = wr && !sync_busy && !sync_held_ff && !i_write_protect &&
                       (i_paddr[5:2] == 4'h0) && i_pstrb[0] &&
                       (i_pwdata[`BIT_SOFT_RESET] ||
                        (i_pwdata[`BIT_ENABLE] != control_a_ff[`BIT_ENABLE]));
   spi_sync_ack #(
      .STAGES(`SYNC_STAGES)
   ) i_spi_sync_ack (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_start(sync_start),
      .o_busy (sync_busy),
      .o_done (sync_done)
   );

   // An access whose crossing already ran must not start it again
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sync_held_ff <= 1'b0;
      end else if (sync_start) begin
         sync_held_ff <= 1'b1;
      end else if (o_pready) begin
         sync_held_ff <= 1'b0;
      end
   end

   // Synchronized writes wait until the crossing ends; others answer one cycle after access
   assign reg_ok = (i_paddr[7:6] == 2'h0);
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         if (access && !o_pready && !sync_busy && !sync_start) begin
            o_pready  <= 1'b1;
            o_pslverr <= !reg_ok || (i_pwrite && pend_rst_ff && !sync_held_ff);
            o_prdata  <= rdata;
         end
      end
   end

   // Control A: enable-protected, write-protectable, soft reset wins
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         control_a_ff <= `RST_CONTROL_A;
         pend_en_ff   <= 1'b0;
         pend_rst_ff  <= 1'b0;
      end else if (sync_done && pend_rst_ff) begin
         control_a_ff <= `RST_CONTROL_A;
         pend_rst_ff  <= 1'b0;
         pend_en_ff   <= 1'b0;
      end else if (wr && o_pready == 1'b0 && !sync_busy && !sync_held_ff &&
                   !i_write_protect && i_paddr[5:2] == 4'h0) begin
         if (i_pstrb[0] && i_pwdata[`BIT_SOFT_RESET]) begin
            control_a_ff[`BIT_SOFT_RESET] <= 1'b1;
            pend_rst_ff                   <= 1'b1;
         end else begin
            if (i_pstrb[0]) begin
               control_a_ff[`BIT_ENABLE] <= i_pwdata[`BIT_ENABLE];
               pend_en_ff <= i_pwdata[`BIT_ENABLE] != control_a_ff[`BIT_ENABLE];
            end
            if (!en_active_ff) begin
               control_a_ff <= ((control_a_ff & ~wmask) | (i_pwdata & wmask)) &
                               `CTRL_A_WMASK;
               control_a_ff[`BIT_ENABLE] <= i_pstrb[0] ? i_pwdata[`BIT_ENABLE]
                                                        : control_a_ff[`BIT_ENABLE];
            end
         end
      end else if (sync_done) begin
         pend_en_ff <= 1'b0;
      end
   end

   // Enable takes effect only when its crossing completes
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         en_active_ff <= 1'b0;
      end else if (sync_done) begin
         en_active_ff <= pend_rst_ff ? 1'b0 : control_a_ff[`BIT_ENABLE];
      end
   end

   // Other registers; soft reset clears all but debug control
   always_ff @(posedge i_mclk) begin
      if (i_rst || (sync_done && pend_rst_ff)) begin
         control_b_ff  <= 32'h0000_0000;
         baud_ff       <= 8'h00;
         irq_en_ff     <= 8'h00;
         addr_match_ff <= 32'h0000_0000;
         data_ff       <= 9'h000;
      end else if (wr && !o_pready && !sync_busy && !pend_rst_ff) begin
         case (i_paddr[5:0] & 6'h3C)
            `OFS_CONTROL_B: begin
               if (!en_active_ff && !i_write_protect) begin
                  control_b_ff <= (control_b_ff & ~wmask) | (i_pwdata & wmask);
               end
            end
            `OFS_BAUD_DIVIDER: begin
               if (!en_active_ff && i_pstrb[0]) baud_ff <= i_pwdata[7:0];
            end
            `OFS_IRQ_EN_CLR: begin
               if (i_pstrb[0]) irq_en_ff <= irq_en_ff & ~i_pwdata[7:0];
               if (i_pstrb[2]) irq_en_ff <= irq_en_ff | i_pwdata[23:16];
            end
            `OFS_ADDRESS_MATCH: begin
               if (!en_active_ff) begin
                  addr_match_ff <= (addr_match_ff & ~wmask) | (i_pwdata & wmask);
               end
            end
            `OFS_DATA_PORT: begin
               if (i_pstrb[0]) data_ff[7:0] <= i_pwdata[7:0];
               if (i_pstrb[1]) data_ff[8]   <= i_pwdata[8];
            end
            default: ;
         endcase
      end
   end

   // Debug control survives soft reset
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         dbg_ff <= 8'h00;
      end else if (wr && !o_pready && !sync_busy && !pend_rst_ff &&
                   i_paddr[5:0] == `OFS_DEBUG_CONTROL && i_pstrb[0]) begin
         dbg_ff <= {7'h00, i_pwdata[0]};
      end
   end

   // Read mux; narrow registers sit in their own byte lanes
   always_comb begin
      rdata = 32'h0000_0000;
      case (i_paddr[5:0] & 6'h3C)
         `OFS_CONTROL_A:     rdata = control_a_ff;
         `OFS_CONTROL_B:     rdata = control_b_ff;
         `OFS_BAUD_DIVIDER:  rdata = {24'h000000, baud_ff};
         `OFS_IRQ_EN_CLR:    rdata = {8'h00, irq_en_ff, 8'h00, irq_en_ff};
         `OFS_IRQ_FLAGS:     rdata = {16'h0000, 8'h00, irq_flags_ff};
         `OFS_SYNC_BUSY:     rdata = {29'h0, 1'b0, pend_en_ff, pend_rst_ff};
         `OFS_ADDRESS_MATCH: rdata = addr_match_ff;
         `OFS_DATA_PORT:     rdata = {23'h0, data_ff};
         `OFS_DEBUG_CONTROL: rdata = {24'h000000, dbg_ff};
         default:            rdata = 32'h0000_0000;
      endcase
   end

   // Pins pass two flip-flops; the third stage feeds edge detection
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sck_sync_ff <= 3'h0;
         ss_sync_ff  <= 3'h7;
         pad_s1_ff   <= 4'h0;
         pad_s2_ff   <= 4'h0;
      end else begin
         sck_sync_ff <= {sck_sync_ff[1:0], i_sck};
         ss_sync_ff  <= {ss_sync_ff[1:0], i_ss_n};
         pad_s1_ff   <= i_pad;
         pad_s2_ff   <= pad_s1_ff;
      end
   end

   assign xmode      = {control_a_ff[`BIT_POLARITY], control_a_ff[`BIT_PHASE]};
   // Leading edge leaves the idle level
   assign lead_edge  = (sck_sync_ff[2] == xmode[1]) && (sck_sync_ff[1] != xmode[1]);
   assign trail_edge = (sck_sync_ff[2] != xmode[1]) && (sck_sync_ff[1] == xmode[1]);
   assign sample_edge = xmode[0] ? trail_edge : lead_edge;
   assign ss_fall    = ss_sync_ff[2] && !ss_sync_ff[1];
   assign rx_bit     = pad_s2_ff[control_a_ff[`BIT_DATA_IN_PAD_LO +: 2]];
   assign rx_byte    = control_a_ff[`BIT_ORDER] ? {rx_bit, shift_ff[7:1]}
                                                : {shift_ff[6:0], rx_bit};

   // Slave receive of the first byte for address check
   always_ff @(posedge i_mclk) begin
      if (i_rst || ss_fall) begin
         bit_cnt_ff <= 3'h0;
         shift_ff   <= 8'h00;
         first_ff   <= 1'b1;
      end else if (en_active_ff && !ss_sync_ff[1] && sample_edge) begin
         shift_ff   <= rx_byte;
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         if (bit_cnt_ff == 3'h7) first_ff <= 1'b0;
      end
   end

   // Address hit: only the addressed format compares; others are plain
   always_ff @(posedge i_mclk) begin
      if (i_rst || ss_fall) begin
         o_addr_hit <= 1'b0;
      end else if (control_a_ff[`BIT_MODE_LO +: 3] == `MODE_SLAVE && en_active_ff &&
                   first_ff && bit_cnt_ff == 3'h7 && sample_edge && !ss_sync_ff[1]) begin
         o_addr_hit <= (control_a_ff[`BIT_FRAME_FORMAT_SELECT_LO +: 4] != `FRAME_FORMAT_SELECT_ADDR) ||
                       (rx_byte == addr_match_ff[7:0]);
      end
   end

   // Events: slave select low, receive complete, address error
   assign ev = {(first_ff && bit_cnt_ff == 3'h7 && sample_edge &&
                 control_a_ff[`BIT_FRAME_FORMAT_SELECT_LO +: 4] == `FRAME_FORMAT_SELECT_ADDR &&
                 rx_byte != addr_match_ff[7:0]),
                3'h0, ss_fall && en_active_ff,
                (bit_cnt_ff == 3'h7 && sample_edge && en_active_ff), 2'h0};

   // Sticky flags: set beats a write-one clear in the same cycle
   always_ff @(posedge i_mclk) begin
      if (i_rst || (sync_done && pend_rst_ff)) begin
         irq_flags_ff <= 8'h00;
      end else if (wr && !o_pready && (i_paddr[5:0] & 6'h3C) == `OFS_IRQ_FLAGS &&
                   i_pstrb[0]) begin
         irq_flags_ff <= (irq_flags_ff & ~i_pwdata[7:0]) | ev;
      end else begin
         irq_flags_ff <= irq_flags_ff | ev;
      end
   end

   // Registered outputs
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_irq               <= 1'b0;
         o_enabled           <= 1'b0;
         o_bit_order_select  <= 1'b0;
         o_serial_data_input <= 1'b0;
      end else begin
         o_irq               <= |(irq_flags_ff & irq_en_ff);
         o_enabled           <= en_active_ff;
         o_bit_order_select  <= control_a_ff[`BIT_ORDER];
         o_serial_data_input <= rx_bit;
      end
   end


   property p_ctl_reset;
      @(posedge i_mclk) $rose(i_rst) |=> control_a_ff == 32'h0000_0000;
   endproperty
   a_ctl_reset: assert property (p_ctl_reset) else $error("control A not cleared");
   property p_protect;
      @(posedge i_mclk) disable iff (i_rst)
      en_active_ff && !sync_done |=> $stable(control_a_ff[31:24]);
   endproperty
   a_protect: assert property (p_protect) else $error("protected field changed");
   property p_en_busy;
      @(posedge i_mclk) disable iff (i_rst)
      sync_start && !i_pwdata[0] |=> pend_en_ff ##[1:6] !pend_en_ff;
   endproperty
   a_en_busy: assert property (p_en_busy) else $error("enable busy stuck");
   property p_en_follow;
      @(posedge i_mclk) disable iff (i_rst)
      sync_done && !pend_rst_ff |=> en_active_ff == control_a_ff[1];
   endproperty
   a_en_follow: assert property (p_en_follow) else $error("enable not applied");
   property p_soft_reset_trigger;
      @(posedge i_mclk) disable iff (i_rst)
      sync_done && pend_rst_ff |=> control_a_ff == 32'h0 && !en_active_ff;
   endproperty
   a_soft_reset_trigger: assert property (p_soft_reset_trigger) else $error("soft reset incomplete");
   property p_irq;
      @(posedge i_mclk) disable iff (i_rst)
      |(irq_flags_ff & irq_en_ff) |=> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");
   property p_route;
      @(posedge i_mclk) disable iff (i_rst)
      ##1 o_serial_data_input == $past(pad_s2_ff[control_a_ff[21:20]]);
   endproperty
   a_route: assert property (p_route) else $error("data input route wrong");
   property p_ready_once;
      @(posedge i_mclk) disable iff (i_rst) o_pready |=> !o_pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("pready held");
   c_soft_reset_trigger: cover property (@(posedge i_mclk) sync_done && pend_rst_ff);
   c_hit: cover property (@(posedge i_mclk) $rose(o_addr_hit));
   c_irq: cover property (@(posedge i_mclk) $rose(o_irq));
endmodule

/* spi_cfg_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SPI_CFG_PARAMS_SVH
`define SPI_CFG_PARAMS_SVH
`define OFS_CONTROL_A      6'h00
`define OFS_CONTROL_B      6'h04
`define OFS_BAUD_DIVIDER   6'h0C
`define OFS_IRQ_EN_CLR     6'h14
`define OFS_IRQ_EN_SET     6'h16
`define OFS_IRQ_FLAGS      6'h18
`define OFS_STATUS_WORD    6'h1A
`define OFS_SYNC_BUSY      6'h1C
`define OFS_ADDRESS_MATCH  6'h24
`define OFS_DATA_PORT      6'h28
`define OFS_DEBUG_CONTROL  6'h30
`define RST_CONTROL_A      32'h0000_0000
`define CTRL_A_WMASK       32'h7F33_019E
`define BIT_SOFT_RESET     0
`define BIT_ENABLE         1
`define BIT_FRAME_FORMAT_SELECT_LO        24
`define BIT_PHASE          28
`define BIT_POLARITY       29
`define BIT_ORDER          30
`define BIT_DATA_IN_PAD_LO 20
`define BIT_MODE_LO        2
`define MODE_SLAVE         3'h2
`define MODE_MASTER        3'h3
`define FRAME_FORMAT_SELECT_PLAIN         4'h0
`define FRAME_FORMAT_SELECT_ADDR          4'h2
`define IRQ_DRE            0
`define IRQ_TXC            1
`define IRQ_RXC            2
`define IRQ_SSL            3
`define IRQ_ERROR          7
`define SYNC_STAGES        3
`endif

/* spi_cfg_pkg.sv */
// Types shared by the SPI configuration bank
package spi_cfg_pkg;
   typedef logic [31:0] word_t;
   typedef logic [1:0]  xfer_mode_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SYNC = 3'b010,
      ST_DONE = 3'b100
   } sync_state_t;
endpackage

/* spi_sync_ack.sv */
// Handshake that models the write crossing into the peripheral domain
`timescale 1ns/10ps
`include "spi_cfg_params.svh"
module spi_sync_ack #(
   parameter int STAGES = `SYNC_STAGES
) (
   // Clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst,
   // Request and completion
   input  wire logic i_start,
   output logic      o_busy,
   output logic      o_done
);
   import spi_cfg_pkg::*;
   sync_state_t    state_ff;
   logic [3:0]     cnt_ff;
   // Counter is four bits wide
   if (STAGES < 1 || STAGES > 15) begin
      $error("STAGES out of range");
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 4'h0;
         o_done   <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (i_start) begin
                  state_ff <= ST_SYNC;
                  cnt_ff   <= 4'(STAGES);
               end
            end
            ST_SYNC: begin
               cnt_ff <= cnt_ff - 4'h1;
               if (cnt_ff == 4'h1) begin
                  state_ff <= ST_DONE;
               end
            end
            ST_DONE: begin
               o_done   <= 1'b1;
               state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end
   assign o_busy = (state_ff != ST_IDLE);
endmodule

/* spi_peer_model.sv */
// Behavioural SPI master that drives the link pins of the bank
`timescale 1ns/10ps
module spi_peer_model (
   // Pad that carries data
   input  wire logic [1:0] i_lane,
   // Link pins
   output logic [3:0]      o_pad,
   output logic            o_sck,
   output logic            o_ss_n
);
   logic dbit;

   initial begin
      dbit = 1'h0;
      o_sck = 1'h0;
      o_ss_n = 1'h1;
   end

   // Unused pads show the inverse so a wrong route cannot pass
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         o_pad[k] = (i_lane == 2'(k)) ? dbit : ~dbit;
      end
   end

   task automatic set_level(input logic v);
      #1;
      dbit = v;
   endtask

   // Link clock of 160 ns, still at the idle level outside frames
   task automatic send_byte(input logic [7:0] b, input logic pol, input logic pha,
                            input logic lsb);
      #2;
      o_sck = pol;
      #80;
      o_ss_n = 1'h0;
      #80;
      for (int i = 0; i < 8; i++) begin
         if (!pha) begin
            dbit = lsb ? b[i] : b[7-i];
         end
         #80;
         o_sck = ~pol;
         if (pha) begin
            dbit = lsb ? b[i] : b[7-i];
         end
         #80;
         o_sck = pol;
      end
      #80;
      o_ss_n = 1'h1;
      dbit = ~dbit;
   endtask
endmodule

/* spi_control_config_bank_tb.sv */
// Self-checking bench for the SPI control and configuration bank
`timescale 1ns/10ps
`include "spi_cfg_params.svh"
module spi_control_config_bank_tb;
   import spi_cfg_pkg::*;
   localparam logic [7:0] A_CA = 8'(`OFS_CONTROL_A);
   localparam logic [7:0] A_IE = 8'(`OFS_IRQ_EN_CLR);
   localparam logic [7:0] A_FL = 8'(`OFS_IRQ_FLAGS);
   localparam logic [7:0] A_SB = 8'(`OFS_SYNC_BUSY);
   localparam logic [7:0] A_AM = 8'(`OFS_ADDRESS_MATCH);
   localparam logic [7:0] A_DB = 8'(`OFS_DEBUG_CONTROL);
   logic       i_mclk = 1'h0;
   logic       rst = 1'h1;
   logic       psel = 1'h0;
   logic       penable = 1'h0;
   logic       pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [3:0] pstrb = 4'h0;
   word_t      pwdata = 32'h0000_0000;
   logic       wprot = 1'h0;
   logic [1:0] lane = 2'h0;
   logic [3:0] pad;
   logic       sck;
   logic       ss_n;
   word_t      prdata;
   logic       pready;
   logic       pslverr;
   logic       sdi;
   logic       enabled;
   logic       order;
   logic       hit;
   logic       irq;
   word_t      rdata;
   logic       perr;
   int         fails = 0;
   int         total_checks = 0;
   int         cyc = 0;

   initial begin
      forever #2.5 i_mclk = ~i_mclk;
   end

   spi_control_config_bank i_spi_control_config_bank (
      .i_mclk(i_mclk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pstrb(pstrb), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_write_protect(wprot), .i_pad(pad), .i_sck(sck), .i_ss_n(ss_n),
      .o_serial_data_input(sdi), .o_enabled(enabled), .o_bit_order_select(order),
      .o_addr_hit(hit), .o_irq(irq));

   spi_peer_model i_spi_peer_model (.i_lane(lane), .o_pad(pad), .o_sck(sck), .o_ss_n(ss_n));

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Ceiling well above the roughly 6000 cycles the tests need
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         final_report();
      end
   end

   task automatic chk(input string nm, input word_t e, input word_t g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // APB request held until pready is sampled high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input word_t d);
      @(posedge i_mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pstrb <= s;
      pwdata <= d;
      @(posedge i_mclk);
      penable <= 1'h1;
      do begin
         @(posedge i_mclk);
      end while (pready !== 1'h1);
      rdata = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] s, input word_t d);
      xfer(1'h1, a, s, d);
   endtask

   task automatic rd(input logic [7:0] a);
      xfer(1'h0, a, 4'hF, 32'h0000_0000);
   endtask

   function automatic word_t cfg(input logic o, input logic [1:0] m, input logic [3:0] f,
                                 input logic [1:0] p, input logic [2:0] md, input logic en);
      word_t w;
      w = '0;
      w[`BIT_ORDER] = o;
      w[`BIT_PHASE +: 2] = m;
      w[`BIT_FRAME_FORMAT_SELECT_LO +: 4] = f;
      w[`BIT_DATA_IN_PAD_LO +: 2] = p;
      w[`BIT_MODE_LO +: 3] = md;
      w[`BIT_ENABLE] = en;
      return w;
   endfunction

   task automatic t_reset;
      rd(A_CA);
      chk("control_a reset", `RST_CONTROL_A, rdata);
      chk("enabled", 32'h0, 32'(enabled));
      $display("test reset done");
   endtask

   task automatic t_lanes;
      wr(A_CA, 4'h8, 32'h4000_0000);
      rd(A_CA);
      chk("byte lane 3", 32'h4000_0000, rdata);
      chk("order pin", 32'h1, 32'(order));
      wr(A_CA, 4'h4, 32'h0030_0000);
      rd(A_CA);
      chk("byte lane 2", 32'h4030_0000, rdata);
      wr(A_CA, 4'hC, 32'h2000_0000);
      rd(A_CA);
      chk("upper half", 32'h2000_0000, rdata);
      rd(A_SB);
      chk("no sync busy", 32'h0, rdata);
      wprot <= 1'h1;
      wr(A_CA, 4'hF, 32'h1000_0000);
      rd(A_CA);
      chk("protected write", 32'h2000_0000, rdata);
      wprot <= 1'h0;
      rd(8'h40);
      chk("unmapped error", 32'h1, 32'(perr));
      $display("test lanes done");
   endtask

   task automatic t_pad;
      logic [2:0] md;
      for (int m = 0; m < 2; m++) begin
         md = m ? `MODE_MASTER : `MODE_SLAVE;
         for (int p = 0; p < 4; p++) begin
            wr(A_CA, 4'hF, cfg(1'h0, 2'h0, `FRAME_FORMAT_SELECT_PLAIN, 2'(p), md, 1'h0));
            lane <= 2'(p);
            for (int v = 0; v < 2; v++) begin
               i_spi_peer_model.set_level(v[0]);
               repeat (6) @(posedge i_mclk);
               chk("routed input", 32'(v[0]), 32'(sdi));
            end
         end
      end
      lane <= 2'h0;
      $display("test pad done");
   endtask

   task automatic t_frames;
      word_t c;
      wr(A_AM, 4'hF, 32'h0000_005A);
      for (int md = 0; md < 4; md++) begin
         for (int od = 0; od < 2; od++) begin
            c = cfg(od[0], md[1:0], `FRAME_FORMAT_SELECT_ADDR, 2'h0, `MODE_SLAVE, 1'h0);
            wr(A_CA, 4'hF, c);
            wr(A_CA, 4'hF, c | 32'h0000_0002);
            @(negedge i_mclk);
            chk("enabled", 32'h1, 32'(enabled));
            rd(A_SB);
            chk("sync done", 32'h0, rdata);
            wr(A_CA, 4'hF, c | 32'h0030_0002);
            rd(A_CA);
            chk("protected", c | 32'h0000_0002, rdata);
            i_spi_peer_model.send_byte(8'h5A, md[1], md[0], od[0]);
            repeat (6) @(posedge i_mclk);
            chk("address hit", 32'h1, 32'(hit));
            i_spi_peer_model.send_byte(8'hA5, md[1], md[0], od[0]);
            repeat (6) @(posedge i_mclk);
            chk("address miss", 32'h0, 32'(hit));
         end
      end
      c = cfg(1'h0, 2'h0, `FRAME_FORMAT_SELECT_PLAIN, 2'h0, `MODE_SLAVE, 1'h0);
      wr(A_CA, 4'hF, c);
      wr(A_CA, 4'hF, c | 32'h0000_0002);
      i_spi_peer_model.send_byte(8'hA5, 1'h0, 1'h0, 1'h0);
      repeat (6) @(posedge i_mclk);
      chk("plain frame hit", 32'h1, 32'(hit));
      $display("test frames done");
   endtask

   task automatic t_irq;
      rd(A_FL);
      chk("mismatch flag", 32'h80, rdata & 32'h80);
      wr(A_IE, 4'h4, 32'h0080_0000);
      @(negedge i_mclk);
      chk("irq on", 32'h1, 32'(irq));
      wr(A_IE, 4'h1, 32'h0000_0080);
      @(negedge i_mclk);
      chk("irq masked", 32'h0, 32'(irq));
      wr(A_IE, 4'h4, 32'h0080_0000);
      wr(A_FL, 4'h1, 32'h0000_0080);
      @(negedge i_mclk);
      chk("irq cleared", 32'h0, 32'(irq));
      $display("test irq done");
   endtask

   task automatic t_soft_reset_trigger;
      wr(A_DB, 4'h1, 32'h0000_0001);
      wr(A_CA, 4'hF, 32'h4000_0003);
      rd(A_CA);
      chk("control_a after soft reset", `RST_CONTROL_A, rdata);
      chk("disabled", 32'h0, 32'(enabled));
      rd(A_DB);
      chk("debug kept", 32'h1, rdata & 32'hFF);
      $display("test soft reset done");
   endtask

   initial begin
      repeat (8) @(posedge i_mclk);
      rst <= 1'h0;
      t_reset();
      t_lanes();
      t_pad();
      t_frames();
      t_irq();
      t_soft_reset_trigger();
      final_report();
   end
endmodule
